//--- verif/pors_supply_model.sv
`timescale 1ns/1ps
`default_nettype none
module pors_supply_model #(
  parameter int NB   = 4,
  parameter int HOLD = 10
) (
  input  wire logic          sys_clk,
  input  wire logic          coreOn,
  input  wire logic [NB-1:0] bankOn,
  output logic               coreGood,
  output logic [NB-1:0]      bankGood
);
  int lowCnt;

  initial begin
    coreGood = 1'b0;
    bankGood = '0;
    lowCnt = 0;
  end

  // ****************
  // Supply behaviour
  // ****************
  // A core that sagged stays down HOLD cycles before it may come back
  // Supplies move on the rising edge so they never race falling-edge stimulus
  always @(posedge sys_clk) begin
    bankGood <= bankOn;
    if (!coreOn) begin
      coreGood <= 1'b0;
      lowCnt <= 0;
    end else if (!coreGood && lowCnt < HOLD) begin
      lowCnt <= lowCnt + 1;
    end else begin
      coreGood <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- verif/power_on_reset_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module power_on_reset_sequencer_bench;
  import pors_pkg::*;
  localparam int HOLD = 10;
  localparam int CFG  = 64;
  localparam int COPY = 16;
  localparam int BANK = 12;
  logic       sys_clk;
  logic       nrst = 1'b0;
  logic       coreOn = 1'b0;
  logic [3:0] bankOn = 4'h0;
  logic       coreGood;
  logic [3:0] bankGood;
  logic       clrEn = 1'b0;
  logic       clrPinN = 1'b1;
  logic       oeEn = 1'b0;
  logic       oePin = 1'b1;
  pors_ctrl_t ctrl;
  logic       copyAct;
  logic       oeN;
  int         nMismatch = 0;
  int         samplesChecked = 0;
  int         cycles = 0;

  pors_supply_model #(.NB(4), .HOLD(HOLD)) i_pors_supply_model (
    .sys_clk(sys_clk), .coreOn(coreOn), .bankOn(bankOn),
    .coreGood(coreGood), .bankGood(bankGood));

  pors_sequencer #(.COPY_CYCLES(COPY), .CFG_CYCLES(CFG),
    .BANK_CYCLES(BANK), .CLR_CYCLES(4)) i_pors_sequencer (
    .sys_clk(sys_clk), .nrst(nrst), .coreSupplyGood(coreGood),
    .ioBankSupplyGood(bankGood), .clearPinEnable(clrEn),
    .deviceWideClearPinN(clrPinN), .outputEnablePinEnable(oeEn),
    .deviceWideOutputEnablePin(oePin), .ctrl(ctrl),
    .configCopyActive(copyAct), .userIoOeN(oeN));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ********
  // Checking
  // ********
  task automatic chk(input string nm, input logic exp, input logic got);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("MISMATCH %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic completeRun();
    $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      nMismatch++;
      completeRun();
    end
  end

  task automatic doReset(input logic ce, input logic oe);
    nrst = 1'b0;
    coreOn = 1'b0;
    bankOn = 4'h0;
    clrEn = ce;
    clrPinN = !ce;
    oeEn = oe;
    oePin = !oe;
    repeat (5) @(negedge sys_clk);
    chk("rst", 1'b1, {ctrl, copyAct, oeN} === 6'h39);
    nrst = 1'b1;
  endtask

  // With the clear pin option off, clear must already be gone whenever the pin hold is dropped
  task automatic toUser(input int lim, output int n);
    n = 0;
    while (ctrl.userMode !== 1'b1 && n < lim) begin
      @(negedge sys_clk);
      n++;
      if (!clrEn && ctrl.ioHoldTristate === 1'b0)
        chk("clrFirst", 1'b0, ctrl.userRegClear);
    end
  endtask

  task automatic powerAll();
    coreOn = 1'b1;
    bankOn = 4'hf;
  endtask

  // *********
  // Scenarios
  // *********
  task automatic tSimul();
    int n;
    doReset(1'b0, 1'b0);
    powerAll();
    repeat (HOLD + 8) @(negedge sys_clk);
    chk("copy", 1'b1, copyAct);
    chk("hold", 1'b1, {ctrl.ioHoldTristate, ctrl.weakPullupEn} === 2'h3);
    toUser(CFG - 4, n);
    chk("user", 1'b1, ctrl.userMode);
    chk("free", 1'b1,
        {ctrl.ioHoldTristate, ctrl.weakPullupEn, oeN} === 3'h0);
    coreOn = 1'b0;
    bankOn = 4'h0;
    repeat (12) @(negedge sys_clk);
    chk("noMon", 1'b1, ctrl.userMode & !copyAct);
  endtask

  task automatic tLate();
    int n;
    doReset(1'b0, 1'b0);
    coreOn = 1'b1;
    bankOn = 4'h7;
    repeat (HOLD + CFG + 8) @(negedge sys_clk);
    chk("gate", 1'b0, ctrl.userMode);
    bankOn = 4'hf;
    toUser(BANK + 8, n);
    chk("late", 1'b1, ctrl.userMode && n >= BANK);
  endtask

  task automatic tRestart();
    int n;
    doReset(1'b0, 1'b0);
    powerAll();
    repeat (HOLD + 8) @(negedge sys_clk);
    coreOn = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk("abort", 1'b0, copyAct);
    coreOn = 1'b1;
    repeat (HOLD + 8) @(negedge sys_clk);
    chk("recopy", 1'b1, copyAct);
    toUser(CFG, n);
    chk("resume", 1'b1, ctrl.userMode && n >= COPY - 8);
  endtask

  task automatic tPins();
    int n;
    doReset(1'b1, 1'b1);
    powerAll();
    toUser(HOLD + CFG, n);
    chk("pinClr", 1'b1, ctrl.userRegClear & !ctrl.ioHoldTristate);
    chk("pinOe", 1'b1, oeN);
    clrPinN = 1'b1;
    oePin = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk("pinRel", 1'b1, {ctrl.userRegClear, oeN} === 2'h0);
  endtask

  initial begin
    tSimul();
    tLate();
    tRestart();
    tPins();
    completeRun();
  end
endmodule
`default_nettype wire

//--- verilog/pors_cfg.svh
`ifndef PORS_CFG_SVH
`define PORS_CFG_SVH
`define PORS_CLK_MHZ        125
`define PORS_CFG_TIME_US    450
`define PORS_BANK_DELAY_US  2
`define PORS_NUM_BANKS      4
`define PORS_COPY_CYCLES    1024
`define PORS_CLR_CYCLES     4
`endif

//--- verilog/pors_pkg.sv
package pors_pkg;
  typedef enum logic [2:0] {
    PORS_WAIT_CORE,
    PORS_COPY,
    PORS_WAIT_BANKS,
    PORS_BANK_DELAY,
    PORS_CLEAR,
    PORS_USER
  } pors_state_t;

  typedef struct packed {
    logic ioHoldTristate;
    logic weakPullupEn;
    logic userRegClear;
    logic userMode;
  } pors_ctrl_t;
endpackage

//--- verilog/pors_sequencer.sv
// Overview of operation
// - After power-up the block copies configuration into SRAM while every user pin is tri-stated with weak pull-ups.
// - On entering user mode the pin hold is dropped and pins belong to the user design.
// - In user mode the supply-good inputs are ignored, so a later drop does not restart configuration.
// - The configuration copy starts when the core supply-good input shows the download threshold.
// - Copy and entry to user mode finish within the configuration time counted from the threshold.
// - User mode also waits for every I/O bank supply-good input.
// - With core and banks good together, user mode comes within the configuration time.
// - If the last bank comes good after the configuration time, user mode comes two microseconds after it.
// - After a core supply drop before user mode the full copy restarts and operation resumes within the configuration time.
// - After the copy all user registers are cleared and released before the pin hold is released.
// - With the clear pin option enabled the register clear follows that pin and may end after the pins are released.
// - With the output-enable pin option enabled the outputs stay tri-stated while that pin holds them off.
`timescale 1ns/1ps
`default_nettype none
`include "pors_cfg.svh"
module pors_sequencer #(
  parameter int NUM_BANKS   = `PORS_NUM_BANKS,
  parameter int COPY_CYCLES = `PORS_COPY_CYCLES,
  parameter int CFG_CYCLES  = `PORS_CFG_TIME_US * `PORS_CLK_MHZ,
  parameter int BANK_CYCLES = `PORS_BANK_DELAY_US * `PORS_CLK_MHZ,
  parameter int CLR_CYCLES  = `PORS_CLR_CYCLES
) (
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  input  wire logic                 coreSupplyGood,
  input  wire logic [NUM_BANKS-1:0] ioBankSupplyGood,
  input  wire logic                 clearPinEnable,
  input  wire logic                 deviceWideClearPinN,
  input  wire logic                 outputEnablePinEnable,
  input  wire logic                 deviceWideOutputEnablePin,
  output var  pors_pkg::pors_ctrl_t ctrl,
  output logic                      configCopyActive,
  output logic                      userIoOeN
);
  import pors_pkg::*;

  localparam int CW = 24;
  // Edges from leaving the bank wait to user mode being visible
  localparam int USER_LAT = CLR_CYCLES + 1;

  // ****************************************************************
  // Reset and input synchronisers
  // ****************************************************************
  logic                 rstMeta_r;
  logic                 rstN_r;
  logic                 coreGood;
  logic [NUM_BANKS-1:0] bankGood;
  logic                 clrPinN;
  logic                 oePin;

  initial begin
    if (NUM_BANKS < 1 || COPY_CYCLES < 1 || BANK_CYCLES < 1 ||
        CLR_CYCLES < 1 || CFG_CYCLES <= COPY_CYCLES + CLR_CYCLES ||
        CFG_CYCLES >= (1 << CW)) begin
      $error("pors_sequencer parameters out of range");
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_r <= 1'b0;
      rstN_r    <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstN_r    <= rstMeta_r;
    end
  end

  pors_sync #(.WIDTH(NUM_BANKS + 3)) uSync (
    .sys_clk (sys_clk),
    .rstN    (rstN_r),
    .asyncIn ({coreSupplyGood, ioBankSupplyGood,
               deviceWideClearPinN, deviceWideOutputEnablePin}),
    .syncOut ({coreGood, bankGood, clrPinN, oePin})
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  pors_state_t    state_r;
  pors_state_t    state_nxt;
  logic [CW-1:0]  phase_r;
  logic [CW-1:0]  phase_nxt;
  logic [CW-1:0]  total_r;
  logic [CW-1:0]  total_nxt;
  pors_ctrl_t     ctrl_r;
  pors_ctrl_t     ctrl_nxt;
  logic           copy_r;
  logic           copy_nxt;
  logic           oeN_r;
  logic           oeN_nxt;
  logic           allBanks;

  assign allBanks = &bankGood;

  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r + 1'b1;
    total_nxt = (total_r == CW'(CFG_CYCLES)) ? total_r : total_r + 1'b1;
    case (state_r)
      PORS_WAIT_CORE: begin
        phase_nxt = '0;
        total_nxt = '0;
        if (coreGood) begin
          state_nxt = PORS_COPY;
        end
      end
      PORS_COPY: begin
        if (phase_r == CW'(COPY_CYCLES - 1)) begin
          phase_nxt = '0;
          state_nxt = PORS_WAIT_BANKS;
        end
      end
      PORS_WAIT_BANKS: begin
        phase_nxt = '0;
        if (allBanks) begin
          // late banks still need the bank settling delay
          state_nxt = (total_r == CW'(CFG_CYCLES)) ? PORS_BANK_DELAY
                                                   : PORS_CLEAR;
        end
      end
      PORS_BANK_DELAY: begin
        if (phase_r == CW'(BANK_CYCLES - CLR_CYCLES - 1) ||
            BANK_CYCLES <= CLR_CYCLES) begin
          phase_nxt = '0;
          state_nxt = PORS_CLEAR;
        end
      end
      PORS_CLEAR: begin
        if (phase_r == CW'(CLR_CYCLES - 1)) begin
          phase_nxt = '0;
          state_nxt = PORS_USER;
        end
      end
      PORS_USER: begin
        phase_nxt = '0;
        total_nxt = total_r; // supplies no longer watched
      end
      default: begin
        state_nxt = PORS_WAIT_CORE;
      end
    endcase
    // Supplies are watched only until user mode, so a core loss here restarts
    if (state_r != PORS_USER && state_r != PORS_WAIT_CORE && !coreGood) begin
      state_nxt = PORS_WAIT_CORE;
    end
  end

  always_comb begin
    ctrl_nxt.userMode       = (state_nxt == PORS_USER);
    ctrl_nxt.ioHoldTristate = !ctrl_nxt.userMode;
    ctrl_nxt.weakPullupEn   = !ctrl_nxt.userMode;
    // Unless the enabled clear pin holds them, registers are released while the pins are still held
    ctrl_nxt.userRegClear   = (state_nxt != PORS_USER &&
                               state_nxt != PORS_CLEAR) ||
                              (state_nxt == PORS_CLEAR &&
                               phase_nxt != CW'(CLR_CYCLES - 1)) ||
                              (clearPinEnable && !clrPinN);
    copy_nxt = (state_nxt == PORS_COPY);
    oeN_nxt  = !ctrl_nxt.userMode ||
               (outputEnablePinEnable && !oePin);
  end

  always_ff @(posedge sys_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      state_r <= PORS_WAIT_CORE;
      phase_r <= '0;
      total_r <= '0;
      ctrl_r  <= '{ioHoldTristate: 1'b1, weakPullupEn: 1'b1,
                   userRegClear: 1'b1, userMode: 1'b0};
      copy_r  <= 1'b0;
      oeN_r   <= 1'b1;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      total_r <= total_nxt;
      ctrl_r  <= ctrl_nxt;
      copy_r  <= copy_nxt;
      oeN_r   <= oeN_nxt;
    end
  end

  assign ctrl             = ctrl_r;
  assign configCopyActive = copy_r;
  assign userIoOeN        = oeN_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_hold_until_user: assert property (
    @(posedge sys_clk) disable iff (!rstN_r)
    !ctrl_r.userMode |-> ctrl_r.ioHoldTristate && ctrl_r.weakPullupEn && oeN_r)
    else $error("pins not held before user mode");
  a_release_in_user: assert property (
    @(posedge sys_clk) disable iff (!rstN_r)
    ctrl_r.userMode |-> !ctrl_r.ioHoldTristate && !ctrl_r.weakPullupEn)
    else $error("pins still held in user mode");
  a_user_sticky: assert property (
    @(posedge sys_clk) disable iff (!rstN_r)
    ctrl_r.userMode |=> ctrl_r.userMode)
    else $error("user mode left on supply change");
  a_copy_start: assert property (
    @(posedge sys_clk) disable iff (!rstN_r)
    state_r == PORS_WAIT_CORE && coreGood |=> state_r == PORS_COPY ##1 copy_r)
    else $error("copy did not start on core good");
  a_bank_gate: assert property (
    @(posedge sys_clk) disable iff (!rstN_r)
    $rose(ctrl_r.userMode) |-> $past(allBanks, 2))
    else $error("user mode without all banks");
  a_user_time: assert property (
    @(posedge sys_clk) disable iff (!rstN_r)
    state_r == PORS_WAIT_BANKS && allBanks && total_r != CW'(CFG_CYCLES)
    |-> ##[1:USER_LAT] ctrl_r.userMode)
    else $error("user mode later than configuration time");
  a_late_bank: assert property (
    @(posedge sys_clk) disable iff (!rstN_r)
    state_r == PORS_WAIT_BANKS && allBanks && total_r == CW'(CFG_CYCLES)
    |=> state_r == PORS_BANK_DELAY)
    else $error("late bank delay skipped");
  a_core_loss: assert property (
    @(posedge sys_clk) disable iff (!rstN_r)
    state_r != PORS_USER && state_r != PORS_WAIT_CORE && !coreGood
    |=> state_r == PORS_WAIT_CORE)
    else $error("core loss did not restart the copy");
  a_clear_order: assert property (
    @(posedge sys_clk) disable iff (!rstN_r)
    $rose(ctrl_r.userMode) && !clearPinEnable |-> !ctrl_r.userRegClear &&
    !$past(ctrl_r.userRegClear))
    else $error("clear released after pins");
  a_clear_pin: assert property (
    @(posedge sys_clk) disable iff (!rstN_r)
    ctrl_r.userMode && clearPinEnable && !clrPinN |=> ctrl_r.userRegClear)
    else $error("clear pin ignored");
  a_oe_pin: assert property (
    @(posedge sys_clk) disable iff (!rstN_r)
    outputEnablePinEnable && !oePin |=> oeN_r)
    else $error("output enable pin ignored");
endmodule
`default_nettype wire

//--- verilog/pors_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pors_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rstN,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  initial begin
    if (WIDTH < 1) begin
      $error("pors_sync needs WIDTH of at least one");
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else begin
      stage1_r <= asyncIn;
      stage2_r <= stage1_r;
    end
  end

  assign syncOut = stage2_r;
endmodule
`default_nettype wire
